/* File: src/lpcc_defines.svh */
// Behaviour
// - with low-frequency input set, external clock may change from 0 to 16 MHz.
// - low-frequency input sampled only in low-power stop and during reset.
// - in normal clocking, lost-clock output high on lock error or missing clock.
// - lost-clock output undriven in reset, low-power stop and low-frequency mode.
// - clock-disable output asserted only while stop is active.
// - logic is static and keeps its state at any clock rate.
// - one clock, an asynchronous reset and a reset input, no separate processor clock.
// - clock-disable asserts when the stop broadcast cycle terminates.
// - in stop, an interrupt above the mask negates clock-disable and restarts lock.
`ifndef LPCC_DEFINES_SVH
`define LPCC_DEFINES_SVH
`define LPCC_ADDR_CTRL 4'h0
`define LPCC_ADDR_STAT 4'h4
`define LPCC_ADDR_IRQ 4'h8
`define LPCC_ADDR_MASK 4'hC
`define LPCC_PST_STOP 4'h6
`define LPCC_PST_RUN 4'h0
`define LPCC_LFO_MAX_MHZ 16
`define LPCC_LOCK_NS 800
`define LPCC_CLK_MHZ 125
`define LPCC_LOCK_CYC ((`LPCC_LOCK_NS * `LPCC_CLK_MHZ) / 1000)
`define LPCC_CTRL_RESET 8'h00
`define LPCC_EV_STOP 0
`define LPCC_EV_WAKE 1
`define LPCC_EV_LOST 2
`endif

/* File: src/lpcc_irq.sv */
`timescale 1ns/1ps
// sticky status bits, write-one-to-clear; a new event beats the clear
module lpcc_irq #(
  parameter int N = 3
) (
  input wire logic clock,
  input wire logic arst_n,
  input wire logic [N-1:0] event_pulse,
  input wire logic [N-1:0] clear,
  input wire logic [N-1:0] mask,
  output logic [N-1:0] status,
  output logic irq
);
  logic [N-1:0] stat_q, stat_d;

  always_comb
  begin
    stat_d = (stat_q & ~clear) | event_pulse;
  end

  always_ff @(posedge clock or negedge arst_n)
  begin
    if (!arst_n)
      stat_q <= '0;
    else
      stat_q <= stat_d;
  end

  assign status = stat_q;
  assign irq = |(stat_q & mask);
endmodule

/* File: src/lpcc_pkg.sv */
package lpcc_pkg;
  typedef enum logic [3:0] {
    LPCC_RUN = 4'b0001,
    LPCC_STOP = 4'b0010,
    LPCC_RELOCK = 4'b0100,
    LPCC_LOST = 4'b1000
  } lpcc_state_t;
  typedef struct packed {
    logic cyc;
    logic stb;
    logic we;
    logic [3:0] adr;
    logic [3:0] sel;
    logic [31:0] dat;
  } lpcc_wb_req_t;
endpackage

/* File: src/lpcc_top.sv */
`timescale 1ns/1ps
`include "lpcc_defines.svh"
// clock supervision and low-power stop control; all logic on the one bus clock
module lpcc_top #(
  parameter int LOCK_CYC = `LPCC_LOCK_CYC
) (
  input wire logic clock,
  input wire logic arst_n,
  input wire logic reset_in,
  input wire logic low_freq_op_in,
  input wire logic low_power_stop_instr,
  input wire logic [2:0] irq_level,
  input wire logic [2:0] irq_mask_level,
  input wire logic lock_error,
  input wire logic clock_absent,
  output logic clock_lost_out,
  output logic clock_lost_oe,
  output logic sys_clock_disable_out,
  output logic [3:0] proc_status_code,
  output logic pll_restart,
  output logic low_freq_mode,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [3:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  output logic irq_out
);
  lpcc_pkg::lpcc_state_t state_q, state_d;
  lpcc_pkg::lpcc_wb_req_t req;
  logic lfo_q, lfo_d;
  logic lost_q, lost_d;
  logic [15:0] lock_q, lock_d;
  logic [2:0] ev;
  logic [2:0] w1c;
  logic [2:0] mask;
  logic [2:0] istat;
  logic stop_req;
  logic stop_go;
  logic wake;
  logic in_stop;

  assign req = '{cyc: wb_cyc_i, stb: wb_stb_i, we: wb_we_i, adr: wb_adr_i, sel: wb_sel_i, dat: wb_dat_i};

  // stop entry from pin pulse or software write, i.e. broadcast termination
  assign stop_go = low_power_stop_instr || stop_req;
  assign wake = irq_level > irq_mask_level;
  assign in_stop = (state_q == lpcc_pkg::LPCC_STOP);

  // clock control state machine; only flops, so state holds at any clock rate
  always_comb
  begin
    state_d = state_q;
    lock_d = lock_q;
    ev = 3'h0;
    if (reset_in)
    begin
      state_d = lpcc_pkg::LPCC_RUN;
      lock_d = 16'h0;
    end
    else
    begin
      case (state_q)
        lpcc_pkg::LPCC_RUN:
        begin
          if (stop_go)
          begin
            state_d = lpcc_pkg::LPCC_STOP;
            ev[`LPCC_EV_STOP] = 1'b1;
          end
          else if (!lfo_q && (lock_error || clock_absent))
          begin
            state_d = lpcc_pkg::LPCC_LOST;
            ev[`LPCC_EV_LOST] = 1'b1;
          end
        end
        lpcc_pkg::LPCC_STOP:
        begin
          if (wake)
          begin
            state_d = lpcc_pkg::LPCC_RELOCK;
            lock_d = LOCK_CYC[15:0];
            ev[`LPCC_EV_WAKE] = 1'b1;
          end
        end
        lpcc_pkg::LPCC_RELOCK:
        begin
          // wait for the restarted loop to settle before checking the clock
          if (lock_q <= 16'h1)
            state_d = lpcc_pkg::LPCC_RUN;
          else
            lock_d = lock_q - 16'h1;
        end
        lpcc_pkg::LPCC_LOST:
        begin
          state_d = lpcc_pkg::LPCC_LOST;
        end
        default:
        begin
          state_d = lpcc_pkg::LPCC_RUN;
        end
      endcase
    end
  end

  // low-frequency input latched only in stop or reset, else held
  always_comb
  begin
    lfo_d = lfo_q;
    if (reset_in || in_stop)
      lfo_d = low_freq_op_in;
    lost_d = lost_q;
    if (reset_in)
      lost_d = 1'b0;
    else if (state_d == lpcc_pkg::LPCC_LOST)
      lost_d = 1'b1;
  end

  always_ff @(posedge clock or negedge arst_n)
  begin
    if (!arst_n)
    begin
      state_q <= lpcc_pkg::LPCC_RUN;
      lock_q <= 16'h0;
      lfo_q <= 1'b0;
      lost_q <= 1'b0;
    end
    else
    begin
      state_q <= state_d;
      lock_q <= lock_d;
      lfo_q <= lfo_d;
      lost_q <= lost_d;
    end
  end

  // pin outputs; the lost-clock pin floats outside normal clocking
  assign clock_lost_out = lost_q;
  assign clock_lost_oe = !(reset_in || in_stop || lfo_q);
  assign sys_clock_disable_out = in_stop;
  assign proc_status_code = in_stop ? `LPCC_PST_STOP : `LPCC_PST_RUN;
  assign pll_restart = (state_q == lpcc_pkg::LPCC_RELOCK);
  assign low_freq_mode = lfo_q;

  lpcc_wb_slave u_wb (
    .clock(clock),
    .arst_n(arst_n),
    .req(req),
    .ack(wb_ack_o),
    .rdata(wb_dat_o),
    .mask(mask),
    .stop_req(stop_req),
    .w1c(w1c),
    .irq_stat(istat),
    .live_stat({2'b00, lfo_q, lost_q, state_q})
  );

  lpcc_irq #(
    .N(3)
  ) u_irq (
    .clock(clock),
    .arst_n(arst_n),
    .event_pulse(ev),
    .clear(w1c),
    .mask(mask),
    .status(istat),
    .irq(irq_out)
  );
endmodule

/* File: src/lpcc_wb_slave.sv */
`timescale 1ns/1ps
`include "lpcc_defines.svh"
// classic wishbone register file; ack one cycle after request, dropped next cycle
module lpcc_wb_slave (
  input wire logic clock,
  input wire logic arst_n,
  input wire lpcc_pkg::lpcc_wb_req_t req,
  output logic ack,
  output logic [31:0] rdata,
  output logic [2:0] mask,
  output logic stop_req,
  output logic [2:0] w1c,
  input wire logic [2:0] irq_stat,
  input wire logic [7:0] live_stat
);
  logic ack_q, ack_d;
  logic [31:0] rdata_q, rdata_d;
  logic [2:0] mask_q, mask_d;
  logic stop_d;
  logic [2:0] w1c_d;
  logic hit;
  logic wr;

  // decode and register; unmapped reads return zero and writes are dropped
  // writes act at the edge where the master samples ack, not one earlier
  always_comb
  begin
    hit = req.cyc && req.stb && !ack_q;
    wr = req.cyc && req.stb && req.we && ack_q;
    ack_d = hit;
    rdata_d = rdata_q;
    mask_d = mask_q;
    stop_d = 1'b0;
    w1c_d = 3'h0;
    if (hit && !req.we)
    begin
      if (req.adr == `LPCC_ADDR_STAT)
        rdata_d = {24'h000000, live_stat};
      else if (req.adr == `LPCC_ADDR_IRQ)
        rdata_d = {29'h0, irq_stat};
      else if (req.adr == `LPCC_ADDR_MASK)
        rdata_d = {29'h0, mask_q};
      else
        rdata_d = 32'h0;
    end
    else if (wr && req.sel[0])
    begin
      if (req.adr == `LPCC_ADDR_CTRL)
        stop_d = req.dat[0]; // software issues the stop broadcast end
      else if (req.adr == `LPCC_ADDR_IRQ)
        w1c_d = req.dat[2:0];
      else if (req.adr == `LPCC_ADDR_MASK)
        mask_d = req.dat[2:0];
    end
  end

  always_ff @(posedge clock or negedge arst_n)
  begin
    if (!arst_n)
    begin
      ack_q <= 1'b0;
      rdata_q <= 32'h0;
      mask_q <= 3'h0;
    end
    else
    begin
      ack_q <= ack_d;
      rdata_q <= rdata_d;
      mask_q <= mask_d;
    end
  end

  // write strobes act in the ack cycle
  assign ack = ack_q;
  assign rdata = rdata_q;
  assign mask = mask_q;
  assign stop_req = stop_d;
  assign w1c = w1c_d;
endmodule

/* File: testbench/lpcc_asserts.sv */
`timescale 1ns/1ps
// watches stop, wake and clock-loss outputs at the top ports
module lpcc_asserts #(
  parameter int LOCK_CYC = 4
) (
  input wire logic clock,
  input wire logic arst_n,
  input wire logic reset_in,
  input wire logic low_power_stop_instr,
  input wire logic [2:0] irq_level,
  input wire logic [2:0] irq_mask_level,
  input wire logic lock_error,
  input wire logic clock_absent,
  input wire logic clock_lost_out,
  input wire logic clock_lost_oe,
  input wire logic sys_clock_disable_out,
  input wire logic [3:0] proc_status_code,
  input wire logic pll_restart,
  input wire logic low_freq_mode
);
  default clocking @(posedge clock); endclocking
  default disable iff (!arst_n);
  logic [7:0] relock_q;
  logic [7:0] relock_d;
  // length of the relock wait, so a stuck restart shows up
  always_comb relock_d = pll_restart ? relock_q + 8'h01 : 8'h00;
  always_ff @(posedge clock or negedge arst_n)
    if (!arst_n)
      relock_q <= 8'h00;
    else
      relock_q <= relock_d;
  property p_stop_code; sys_clock_disable_out |-> proc_status_code == 4'h6; endproperty
  a_stop_code: assert property (p_stop_code) else $error("stop code wrong");
  property p_stop_enter; low_power_stop_instr && !reset_in && !sys_clock_disable_out && !pll_restart
    && !clock_lost_out && !lock_error && !clock_absent |=> sys_clock_disable_out; endproperty
  a_stop_enter: assert property (p_stop_enter) else $error("stop not entered");
  property p_wake; sys_clock_disable_out && irq_level > irq_mask_level && !reset_in
    |=> !sys_clock_disable_out && pll_restart; endproperty
  a_wake: assert property (p_wake) else $error("no wake");
  property p_relock; relock_q <= LOCK_CYC + 1; endproperty
  a_relock: assert property (p_relock) else $error("relock too long");
  property p_lost_set; !reset_in && !sys_clock_disable_out && !pll_restart && !low_freq_mode
    && !low_power_stop_instr && (lock_error || clock_absent) |=> clock_lost_out; endproperty
  a_lost_set: assert property (p_lost_set) else $error("loss not flagged");
  property p_lost_hold; clock_lost_out && !reset_in |=> clock_lost_out; endproperty
  a_lost_hold: assert property (p_lost_hold) else $error("loss flag dropped");
  property p_oe_off; reset_in || sys_clock_disable_out || low_freq_mode |-> !clock_lost_oe; endproperty
  a_oe_off: assert property (p_oe_off) else $error("loss pin driven");
  property p_lfo_ignored; !reset_in && !sys_clock_disable_out |=> $stable(low_freq_mode); endproperty
  a_lfo_ignored: assert property (p_lfo_ignored) else $error("lfo taken in run");
  property p_reset_clears; reset_in |=> !clock_lost_out && !sys_clock_disable_out; endproperty
  a_reset_clears: assert property (p_reset_clears) else $error("reset ignored");
endmodule
bind lpcc_top lpcc_asserts #(.LOCK_CYC(LOCK_CYC)) u_asserts (.*);

/* File: testbench/lpcc_sysctl_model.sv */
`timescale 1ns/1ps
// board logic: pull-down on the loss line, resets the device after a loss
module lpcc_sysctl_model (
  input wire logic clock,
  input wire logic arst_n,
  input wire logic clock_lost_out,
  input wire logic clock_lost_oe,
  output logic reset_in
);
  logic lost_wire;
  logic [1:0] cnt_q;
  // undriven line reads low through the pull-down
  assign lost_wire = clock_lost_oe ? clock_lost_out : 1'b0;
  assign reset_in = cnt_q != 2'h0;
  // three cycles of reset once loss is seen
  always_ff @(posedge clock or negedge arst_n)
    if (!arst_n)
      cnt_q <= 2'h0;
    else if (lost_wire && cnt_q == 2'h0)
      cnt_q <= 2'h3;
    else if (cnt_q != 2'h0)
      cnt_q <= cnt_q - 2'h1;
endmodule

/* File: testbench/test_low_power_clock_control.sv */
`timescale 1ns/1ps
// register and pin sequences for the clock supervisor
module test_low_power_clock_control;
  logic clock = 1'b0, arst_n = 1'b0, low_freq_op_in = 1'b0, low_power_stop_instr = 1'b0;
  logic lock_error = 1'b0, clock_absent = 1'b0, wb_cyc_i = 1'b0, wb_stb_i = 1'b0, wb_we_i = 1'b0;
  logic [2:0] irq_level = 3'h0, irq_mask_level = 3'h7;
  logic [3:0] wb_adr_i = 4'h0, wb_sel_i = 4'hF;
  logic [31:0] wb_dat_i = 32'h0, wb_dat_o, rd_v;
  logic reset_in, clock_lost_out, clock_lost_oe, sys_clock_disable_out, pll_restart, low_freq_mode;
  logic wb_ack_o, irq_out;
  logic [3:0] proc_status_code;
  int failures = 0, check_count = 0, cycles = 0;
  // steady clock, never altered in normal mode
  always #4 clock = ~clock;
  lpcc_top #(.LOCK_CYC(4)) i_lpcc_top (.*);
  lpcc_sysctl_model i_lpcc_sysctl_model (.*);
  task close_out;
    $display("checks %0d mismatches %0d", check_count, failures);
    if (failures == 0 && check_count > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  task chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp)
    begin
      failures++;
      $display("[ERR] t=%0t got %h exp %h", $time, got, exp);
    end
  endtask
  // classic cycle, held until ack is sampled
  task wb(input logic we, input logic [3:0] a, input logic [31:0] d);
    @(posedge clock);
    {wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_dat_i} <= {2'b11, we, a, d};
    do @(posedge clock); while (wb_ack_o !== 1'b1);
    rd_v = wb_dat_o;
    {wb_cyc_i, wb_stb_i, wb_we_i} <= 3'b000;
  endtask
  task step(input int n);
    repeat (n) @(posedge clock);
    #1;
  endtask
  task irq_to(input logic [2:0] lv);
    @(posedge clock);
    irq_level <= lv;
    step(2);
  endtask
  // hang guard
  always @(posedge clock)
  begin
    cycles++;
    if (cycles > 2000)
    begin
      failures++;
      close_out;
    end
  end
  initial
  begin
    repeat (16) @(posedge clock);
    arst_n <= 1'b1;
    step(1);
    chk(clock_lost_oe, 1'b1);
    wb(1'b0, 4'h4, 32'h0);
    chk(rd_v, 32'h01);
    @(posedge clock);
    low_power_stop_instr <= 1'b1;
    @(posedge clock);
    low_power_stop_instr <= 1'b0;
    #1;
    chk({proc_status_code, sys_clock_disable_out, clock_lost_oe}, 6'h1A);
    @(posedge clock);
    low_freq_op_in <= 1'b1;
    step(3);
    chk(low_freq_mode, 1'b1);
    @(posedge clock);
    irq_mask_level <= 3'h2;
    irq_to(3'h3);
    chk({sys_clock_disable_out, pll_restart}, 2'b01);
    @(posedge clock);
    low_freq_op_in <= 1'b0;
    irq_to(3'h0);
    chk({low_freq_mode, clock_lost_oe}, 2'b10);
    $display("test low-frequency wake done");
    wb(1'b1, 4'h0, 32'h1);
    step(2);
    chk({sys_clock_disable_out, low_freq_mode}, 2'b10);
    irq_to(3'h1);
    chk(sys_clock_disable_out, 1'b1);
    irq_to(3'h5);
    irq_to(3'h0);
    chk(sys_clock_disable_out, 1'b0);
    $display("test masked wake done");
    wb(1'b0, 4'h8, 32'h0);
    chk(rd_v[2:0], 3'h3);
    wb(1'b1, 4'hC, 32'h0);
    step(1);
    chk(irq_out, 1'b0);
    wb(1'b1, 4'hC, 32'h7);
    step(1);
    chk(irq_out, 1'b1);
    wb(1'b1, 4'h8, 32'h3);
    step(1);
    chk(irq_out, 1'b0);
    wb(1'b0, 4'h2, 32'h0);
    chk(rd_v, 32'h0);
    $display("test registers done");
    @(posedge clock);
    clock_absent <= 1'b1;
    @(posedge clock);
    clock_absent <= 1'b0;
    #1;
    chk({clock_lost_out, clock_lost_oe}, 2'b11);
    step(8);
    chk(clock_lost_out, 1'b0);
    wb(1'b0, 4'h4, 32'h0);
    chk(rd_v, 32'h01);
    $display("test clock loss done");
    close_out;
  end
endmodule
